// ==== rtl/otp_param_store.sv ====
`timescale 1ns/10ps
`default_nettype none
module otp_param_store #(
  parameter logic [7:0] FACTORY_CLOCK_REF = 8'h00,
  parameter logic [7:0] FACTORY_THERMAL = 8'h00,
  parameter int STRAP_W = 3
) (
  // clock and reset
  input wire logic mclk_i,
  input wire logic rst_n_i,
  // commands from the frame layer
  input wire logic cmd_valid_i,
  input wire logic [1:0] cmd_op_i,
  input wire logic [2:0] cmd_addr_i,
  input wire logic [7:0] cmd_data_i,
  output logic cmd_ready_o,
  // readback and command result
  output logic rd_valid_o,
  output logic [7:0] rd_data_o,
  output logic refused_o,
  // strap pins and motion status
  input wire logic [STRAP_W-1:0] strap_pin_bits_i,
  input wire logic motor_stopped_i,
  // node location identifier
  output logic [6:0] node_location_id_o,
  // coil current setpoint
  output logic [3:0] coil_current_code_o,
  output logic [9:0] coil_current_ma_o,
  // motion parameters
  output logic [1:0] microstep_resolution_o,
  output logic [4:0] microstep_div_o,
  output logic shaft_dir_o,
  output logic [3:0] speed_max_o,
  output logic [3:0] speed_min_o,
  output logic [3:0] accel_o,
  output logic [10:0] safe_park_target_o,
  // calibration trims
  output logic [3:0] clock_source_trim_o,
  output logic [3:0] reference_current_trim_o,
  output logic [2:0] overtemp_limit_trim_o,
  output logic [3:0] bandgap_trim_o
);

  // ****************************************************************
  // state
  // ****************************************************************
  typedef struct packed {
    otp_store_pkg::fuse_state_e st;
    logic [7:0][7:0] fuse;
    logic [7:0][7:0] work;
    logic [otp_store_pkg::CNT_W-1:0] cnt;
    logic [2:0] addr;
    logic [7:0] mask;
    logic [7:0] rd_data;
    logic rd_valid;
    logic refused;
    logic [6:0] node;
    logic [3:0] coil;
    logic [9:0] ma;
  } store_s;

  store_s q;
  store_s d;
  logic [STRAP_W-1:0] strap_s;
  logic take;
  logic user_lock;
  logic trim_lock;
  logic addr_locked;
  logic [7:0] stored_field;
  logic [7:0] read_byte;
  logic [3:0] pa_nib;

  // ****************************************************************
  // strap pin synchroniser
  // ****************************************************************
  strap_sync #(
    .WIDTH(STRAP_W)
  ) u_strap_sync (
    .mclk_i(mclk_i),
    .rst_n_i(rst_n_i),
    .async_i(strap_pin_bits_i),
    .sync_o(strap_s)
  );

  // ****************************************************************
  // decode
  // ****************************************************************
  assign take = cmd_valid_i && (q.st == otp_store_pkg::ST_IDLE);
  assign user_lock =
    q.fuse[otp_store_pkg::OFS_STEP_LOCKS][otp_store_pkg::BIT_USER_LOCK];
  assign trim_lock =
    q.fuse[otp_store_pkg::OFS_STEP_LOCKS][otp_store_pkg::BIT_FACTORY_LOCK];
  // user lock covers the whole array, factory lock the trim bytes
  assign addr_locked = user_lock ||
    (trim_lock && (cmd_addr_i <= otp_store_pkg::OFS_CALIB_THERMAL));
  assign pa_nib = q.work[otp_store_pkg::OFS_NODE_ADDRESS][3:0];

  // bits that physically exist as fuses in the addressed byte
  always_comb begin
    if (cmd_addr_i == otp_store_pkg::OFS_NODE_ADDRESS) begin
      stored_field = ~otp_store_pkg::STRAP_FIELD;
    end else if (cmd_addr_i == otp_store_pkg::OFS_STEP_LOCKS) begin
      stored_field = otp_store_pkg::STEP_LOCK_FIELD;
    end else begin
      stored_field = otp_store_pkg::FULL_FIELD;
    end
  end

  // readback splices the live strap level into byte 2
  always_comb begin
    read_byte = q.fuse[cmd_addr_i];
    if (cmd_addr_i == otp_store_pkg::OFS_NODE_ADDRESS) begin
      read_byte[6:4] = strap_s;
    end
  end

  // ****************************************************************
  // next state
  // ****************************************************************
  always_comb begin
    d = q;
    d.rd_valid = 1'b0;
    d.refused = 1'b0;
    case (q.st)
      otp_store_pkg::ST_LOAD: begin
        d.work = q.fuse;
        d.st = otp_store_pkg::ST_IDLE;
      end
      otp_store_pkg::ST_IDLE: begin
        if (take) begin
          case (cmd_op_i)
            otp_store_pkg::OP_PROGRAM: begin
              if (addr_locked) begin
                d.refused = 1'b1;
              end else begin
                // only bits still at zero are zapped
                d.mask = cmd_data_i & ~q.fuse[cmd_addr_i] &
                  stored_field;
                d.addr = cmd_addr_i;
                d.cnt = otp_store_pkg::CNT_W'(otp_store_pkg::ZAP_CYCLES - 1);
                d.st = otp_store_pkg::ST_ZAP;
              end
            end
            otp_store_pkg::OP_READ: begin
              d.rd_data = read_byte;
              d.rd_valid = 1'b1;
              d.work = q.fuse;
            end
            otp_store_pkg::OP_RELOAD: begin
              d.work = q.fuse;
            end
            default: begin
              // RAM override; address nibble and trims stay fuse-held
              if (cmd_addr_i == otp_store_pkg::OFS_NODE_ADDRESS) begin
                d.work[cmd_addr_i][otp_store_pkg::BIT_ADDR_SWAP] =
                  cmd_data_i[otp_store_pkg::BIT_ADDR_SWAP];
              end else if (cmd_addr_i >=
                otp_store_pkg::OFS_COIL_CURRENT) begin
                d.work[cmd_addr_i] = cmd_data_i;
              end
            end
          endcase
        end
      end
      otp_store_pkg::ST_ZAP: begin
        if (q.cnt == '0) begin
          // fuses change; working copy waits for read or reload
          d.fuse[q.addr] = q.fuse[q.addr] | q.mask;
          d.st = otp_store_pkg::ST_IDLE;
        end else begin
          d.cnt = q.cnt - 1'b1;
        end
      end
      default: begin
        d.st = otp_store_pkg::ST_IDLE;
      end
    endcase
    // node identifier composition
    if (q.work[otp_store_pkg::OFS_NODE_ADDRESS]
        [otp_store_pkg::BIT_ADDR_SWAP]) begin
      d.node = {strap_s, pa_nib};
    end else begin
      d.node = {pa_nib, strap_s};
    end
    // coil current setpoint
    if (motor_stopped_i) begin
      d.coil = q.work[otp_store_pkg::OFS_COIL_CURRENT][3:0];
    end else begin
      d.coil = q.work[otp_store_pkg::OFS_COIL_CURRENT][7:4];
    end
    d.ma = otp_store_pkg::COIL_MA[d.coil];
  end

  // ****************************************************************
  // register
  // ****************************************************************
  always_ff @(posedge mclk_i) begin
    if (!rst_n_i) begin
      q <= '0;
      q.st <= otp_store_pkg::ST_LOAD;
      // delivery image: trims and factory lock already zapped
      q.fuse[otp_store_pkg::OFS_CALIB_CLOCK_REF] <= FACTORY_CLOCK_REF;
      q.fuse[otp_store_pkg::OFS_CALIB_THERMAL] <=
        FACTORY_THERMAL | otp_store_pkg::THERMAL_FIXED_ONE;
      q.fuse[otp_store_pkg::OFS_STEP_LOCKS] <=
        otp_store_pkg::STEP_LOCK_DELIVERY;
    end else begin
      q <= d;
    end
  end

  // ****************************************************************
  // outputs
  // ****************************************************************
  assign cmd_ready_o = (q.st == otp_store_pkg::ST_IDLE);
  assign rd_valid_o = q.rd_valid;
  assign rd_data_o = q.rd_data;
  assign refused_o = q.refused;
  assign node_location_id_o = q.node;
  assign coil_current_code_o = q.coil;
  assign coil_current_ma_o = q.ma;
  assign microstep_resolution_o =
    q.work[otp_store_pkg::OFS_STEP_LOCKS][3:2];
  assign microstep_div_o =
    otp_store_pkg::STEP_DIV_BASE << microstep_resolution_o;
  assign shaft_dir_o =
    q.work[otp_store_pkg::OFS_PARK_HIGH][otp_store_pkg::BIT_SHAFT];
  assign speed_max_o = q.work[otp_store_pkg::OFS_SPEED_LIMITS][7:4];
  assign speed_min_o = q.work[otp_store_pkg::OFS_SPEED_LIMITS][3:0];
  assign accel_o = q.work[otp_store_pkg::OFS_PARK_HIGH][3:0];
  assign safe_park_target_o = {q.work[otp_store_pkg::OFS_PARK_HIGH][7:5],
    q.work[otp_store_pkg::OFS_PARK_LOW]};
  assign clock_source_trim_o = q.work[otp_store_pkg::OFS_CALIB_CLOCK_REF][7:4];
  assign reference_current_trim_o =
    q.work[otp_store_pkg::OFS_CALIB_CLOCK_REF][3:0];
  assign overtemp_limit_trim_o = q.work[otp_store_pkg::OFS_CALIB_THERMAL][6:4];
  assign bandgap_trim_o = q.work[otp_store_pkg::OFS_CALIB_THERMAL][3:0];

  // ****************************************************************
  // checks
  // ****************************************************************
  default clocking cb @(posedge mclk_i);
  endclocking
  default disable iff (!rst_n_i);

  a_fuse_never_clear: assert property (
    (q.fuse & $past(q.fuse)) == $past(q.fuse))
    else $error("a fuse bit went from one to zero");

  a_user_lock_refuse: assert property (
    take && cmd_op_i == otp_store_pkg::OP_PROGRAM && user_lock
    |=> refused_o && cmd_ready_o && q.fuse == $past(q.fuse))
    else $error("program under user lock was not refused");

  a_trim_lock_refuse: assert property (
    take && cmd_op_i == otp_store_pkg::OP_PROGRAM && trim_lock &&
    cmd_addr_i <= otp_store_pkg::OFS_CALIB_THERMAL
    |=> refused_o && $stable(q.work))
    else $error("program of trim byte under factory lock not refused");

  a_zap_busy_span: assert property (
    take && cmd_op_i == otp_store_pkg::OP_PROGRAM && !addr_locked
    |=> !cmd_ready_o [*8] ##[110:130] cmd_ready_o)
    else $error("zap did not hold the store busy for its time");

  a_zap_no_effect: assert property (
    q.st == otp_store_pkg::ST_ZAP |=> $stable(q.work))
    else $error("working copy changed during a zap");

  a_reload_takes: assert property (
    take && cmd_op_i == otp_store_pkg::OP_RELOAD
    |=> q.work == $past(q.fuse))
    else $error("reload did not copy fuses to working parameters");

  a_read_strap: assert property (
    take && cmd_op_i == otp_store_pkg::OP_READ &&
    cmd_addr_i == otp_store_pkg::OFS_NODE_ADDRESS
    |=> rd_valid_o && rd_data_o[6:4] == $past(strap_s))
    else $error("byte 2 readback does not show strap pins");

  a_nibble_guard: assert property (
    take && cmd_op_i == otp_store_pkg::OP_LOAD_PARAM
    |=> q.work[otp_store_pkg::OFS_NODE_ADDRESS][6:0] ==
      $past(q.work[otp_store_pkg::OFS_NODE_ADDRESS][6:0]))
    else $error("RAM write altered the address nibble");

  a_node_compose: assert property (
    !q.work[otp_store_pkg::OFS_NODE_ADDRESS][otp_store_pkg::BIT_ADDR_SWAP]
    |=> node_location_id_o == {$past(pa_nib), $past(strap_s)})
    else $error("node identifier order wrong with swap clear");

  a_hold_current: assert property (
    motor_stopped_i ##1 motor_stopped_i
    |-> coil_current_code_o ==
      $past(q.work[otp_store_pkg::OFS_COIL_CURRENT][3:0]))
    else $error("stopped motor not at hold current");

  a_run_current: assert property (
    !motor_stopped_i ##1 !motor_stopped_i
    |-> coil_current_code_o ==
      $past(q.work[otp_store_pkg::OFS_COIL_CURRENT][7:4]))
    else $error("moving motor not at run current");

  a_swap_compose: assert property (
    q.work[otp_store_pkg::OFS_NODE_ADDRESS][otp_store_pkg::BIT_ADDR_SWAP]
    |=> node_location_id_o == {$past(strap_s), $past(pa_nib)})
    else $error("node identifier order wrong with swap set");

  a_zap_fresh_bits: assert property (
    q.st == otp_store_pkg::ST_ZAP |-> (q.mask & q.fuse[q.addr]) == 8'h00)
    else $error("zap aimed at a bit that already reads one");

  a_strap_not_fused: assert property (
    q.st == otp_store_pkg::ST_ZAP &&
    q.addr == otp_store_pkg::OFS_NODE_ADDRESS
    |-> (q.mask & otp_store_pkg::STRAP_FIELD) == 8'h00)
    else $error("zap reached a strap bit position");

  // byte that a finishing zap may touch
  logic [63:0] zap_span;
  assign zap_span = 64'(8'hff) << {q.addr, 3'h0};

  a_zap_one_byte: assert property (
    q.st == otp_store_pkg::ST_ZAP && q.cnt == '0
    |=> (q.fuse & ~$past(zap_span)) == ($past(q.fuse) & ~$past(zap_span)))
    else $error("zap changed a byte other than the addressed one");

  a_refused_still: assert property (
    take && cmd_op_i == otp_store_pkg::OP_PROGRAM && addr_locked
    |=> refused_o && cmd_ready_o && $stable(q.work) && $stable(q.fuse))
    else $error("refused program changed state");

  a_read_loads: assert property (
    take && cmd_op_i == otp_store_pkg::OP_READ
    |=> q.work == $past(q.fuse))
    else $error("read did not copy fuses to working parameters");

  a_trim_ram_fixed: assert property (
    take && cmd_op_i == otp_store_pkg::OP_LOAD_PARAM &&
    cmd_addr_i <= otp_store_pkg::OFS_CALIB_THERMAL
    |=> $stable(q.work))
    else $error("RAM write altered a calibration byte");

  a_trims_delivered: assert property (
    q.fuse[otp_store_pkg::OFS_CALIB_CLOCK_REF] == FACTORY_CLOCK_REF &&
    q.fuse[otp_store_pkg::OFS_CALIB_THERMAL][7] == 1'b1)
    else $error("calibration bytes lost their delivered value");

endmodule // otp_param_store
`default_nettype wire

// ==== rtl/otp_store_pkg.sv ====
package otp_store_pkg;

  // ****************************************************************
  // timing
  // ****************************************************************
  localparam int CLK_MHZ = 125;
  localparam int ZAP_TIME_NS = 1000;
  localparam int ZAP_CYCLES = (ZAP_TIME_NS * CLK_MHZ + 999) / 1000;
  localparam int CNT_W = 8;

  // ****************************************************************
  // byte offsets
  // ****************************************************************
  localparam logic [2:0] OFS_CALIB_CLOCK_REF = 3'h0;
  localparam logic [2:0] OFS_CALIB_THERMAL = 3'h1;
  localparam logic [2:0] OFS_NODE_ADDRESS = 3'h2;
  localparam logic [2:0] OFS_COIL_CURRENT = 3'h3;
  localparam logic [2:0] OFS_SPEED_LIMITS = 3'h4;
  localparam logic [2:0] OFS_PARK_HIGH = 3'h5;
  localparam logic [2:0] OFS_PARK_LOW = 3'h6;
  localparam logic [2:0] OFS_STEP_LOCKS = 3'h7;

  // ****************************************************************
  // field positions and masks
  // ****************************************************************
  localparam int BIT_ADDR_SWAP = 7;
  localparam int BIT_SHAFT = 4;
  localparam int BIT_FACTORY_LOCK = 1;
  localparam int BIT_USER_LOCK = 0;
  localparam logic [7:0] STRAP_FIELD = 8'h70;
  localparam logic [7:0] STEP_LOCK_FIELD = 8'h0f;
  localparam logic [7:0] FULL_FIELD = 8'hff;

  // ****************************************************************
  // factory state at delivery
  // ****************************************************************
  localparam logic [7:0] THERMAL_FIXED_ONE = 8'h80;
  localparam logic [7:0] STEP_LOCK_DELIVERY = 8'h02;

  // ****************************************************************
  // command codes
  // ****************************************************************
  localparam logic [1:0] OP_PROGRAM = 2'h0;
  localparam logic [1:0] OP_READ = 2'h1;
  localparam logic [1:0] OP_RELOAD = 2'h2;
  localparam logic [1:0] OP_LOAD_PARAM = 2'h3;

  // ****************************************************************
  // step resolution divisor for code 00 (half)
  // ****************************************************************
  localparam logic [4:0] STEP_DIV_BASE = 5'h02;

  // ****************************************************************
  // coil current table in mA: 59 .. 800
  // ****************************************************************
  localparam logic [9:0] COIL_MA [16] = '{
    10'h03b, 10'h047, 10'h054, 10'h064, 10'h077, 10'h08d, 10'h0a8, 10'h0c8,
    10'h0ee, 10'h11b, 10'h150, 10'h190, 10'h1dc, 10'h236, 10'h2a1, 10'h320
  };

  typedef enum logic [1:0] {ST_LOAD, ST_IDLE, ST_ZAP} fuse_state_e;

endpackage

// ==== rtl/strap_sync.sv ====
`timescale 1ns/10ps
`default_nettype none
module strap_sync #(
  parameter int WIDTH = 3
) (
  // clock and reset
  input wire logic mclk_i,
  input wire logic rst_n_i,
  // asynchronous level in, synchronised level out
  input wire logic [WIDTH-1:0] async_i,
  output logic [WIDTH-1:0] sync_o
);

  logic [WIDTH-1:0] meta_q;
  logic [WIDTH-1:0] sync_q;

  always_ff @(posedge mclk_i) begin
    if (!rst_n_i) begin
      meta_q <= '0;
      sync_q <= '0;
    end else begin
      meta_q <= async_i;
      sync_q <= meta_q;
    end
  end

  assign sync_o = sync_q;

endmodule // strap_sync
`default_nettype wire

// ==== testbench/lin_master_model.sv ====
`timescale 1ns/10ps
`default_nettype none
module lin_master_model (
  // clock
  input wire logic mclk_i,
  // command channel
  input wire logic cmd_ready_i,
  output logic cmd_valid_o,
  output logic [1:0] cmd_op_o,
  output logic [2:0] cmd_addr_o,
  output logic [7:0] cmd_data_o
);
  logic stuck;

  initial begin
    cmd_valid_o = 1'b0;
    cmd_op_o = 2'h1;
    cmd_addr_o = 3'h0;
    cmd_data_o = 8'h00;
    stuck = 1'b0;
  end

  // ****************************************************************
  // one command, held until the store takes it
  // ****************************************************************
  task automatic issue(input logic [1:0] op, input logic [2:0] addr,
                       input logic [7:0] data);
    int n;
    n = 0;
    @(posedge mclk_i);
    cmd_valid_o <= 1'b1;
    cmd_op_o <= op;
    cmd_addr_o <= addr;
    cmd_data_o <= data;
    do begin
      @(negedge mclk_i);
      n++;
    end while (cmd_ready_i !== 1'b1 && n < 400);
    if (n >= 400) begin
      stuck = 1'b1;
    end
    @(posedge mclk_i);
    // released qualifiers stop showing the last value
    cmd_valid_o <= 1'b0;
    cmd_op_o <= ~op;
    cmd_addr_o <= ~addr;
    cmd_data_o <= ~data;
  endtask
endmodule // lin_master_model
`default_nettype wire

// ==== testbench/test_otp_param_store.sv ====
`timescale 1ns/10ps
`default_nettype none
module test_otp_param_store;
  logic mclk_i = 1'b0;
  logic rst_n_i = 1'b0;
  logic motor_stopped_i = 1'b0;
  logic [2:0] strap_pin_bits_i = 3'h5;
  logic cmd_valid, cmd_ready, rd_valid_o, refused_o, shaft_dir_o;
  logic [1:0] cmd_op, microstep_resolution_o;
  logic [2:0] cmd_addr, overtemp_limit_trim_o;
  logic [7:0] cmd_data, rd_data_o;
  logic [6:0] node_location_id_o;
  logic [3:0] coil_current_code_o, clock_source_trim_o;
  logic [3:0] reference_current_trim_o, bandgap_trim_o;
  logic [9:0] coil_current_ma_o;
  logic [4:0] microstep_div_o;
  logic [3:0] speed_max_o, speed_min_o, accel_o;
  logic [10:0] safe_park_target_o;
  logic [7:0] img [8] = '{8'h5a, 8'h93, 8'h50, 8'h00, 8'h00, 8'h00,
                          8'h00, 8'h02};
  int fails = 0;
  int tests_run = 0;

  always #4 mclk_i = ~mclk_i;

  lin_master_model u_master (.mclk_i(mclk_i), .cmd_ready_i(cmd_ready),
    .cmd_valid_o(cmd_valid), .cmd_op_o(cmd_op), .cmd_addr_o(cmd_addr),
    .cmd_data_o(cmd_data));

  otp_param_store #(.FACTORY_CLOCK_REF(8'h5a), .FACTORY_THERMAL(8'h13))
  u_dut (.mclk_i(mclk_i), .rst_n_i(rst_n_i), .cmd_valid_i(cmd_valid),
    .cmd_op_i(cmd_op), .cmd_addr_i(cmd_addr), .cmd_data_i(cmd_data),
    .cmd_ready_o(cmd_ready), .rd_valid_o(rd_valid_o),
    .rd_data_o(rd_data_o), .refused_o(refused_o),
    .strap_pin_bits_i(strap_pin_bits_i), .motor_stopped_i(motor_stopped_i),
    .node_location_id_o(node_location_id_o),
    .coil_current_code_o(coil_current_code_o),
    .coil_current_ma_o(coil_current_ma_o),
    .microstep_resolution_o(microstep_resolution_o),
    .microstep_div_o(microstep_div_o), .shaft_dir_o(shaft_dir_o),
    .speed_max_o(speed_max_o), .speed_min_o(speed_min_o),
    .accel_o(accel_o), .safe_park_target_o(safe_park_target_o),
    .clock_source_trim_o(clock_source_trim_o),
    .reference_current_trim_o(reference_current_trim_o),
    .overtemp_limit_trim_o(overtemp_limit_trim_o),
    .bandgap_trim_o(bandgap_trim_o));

  // ****************************************************************
  // tasks
  // ****************************************************************
  task automatic test_done;
    $display("fails=%0d tests_run=%0d", fails, tests_run);
    if (fails == 0 && tests_run > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask

  task automatic check(input logic [15:0] got, input logic [15:0] exp);
    tests_run++;
    if (got !== exp) begin
      fails++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic cmd(input logic [1:0] op, input logic [2:0] a,
                     input logic [7:0] d);
    u_master.issue(op, a, d);
    if (u_master.stuck !== 1'b0) begin
      fails++;
      test_done();
    end
  endtask

  task automatic rd(input logic [2:0] a, input logic [7:0] e);
    cmd(otp_store_pkg::OP_READ, a, 8'h00);
    @(negedge mclk_i);
    check(16'(rd_valid_o), 16'h0001);
    check(16'(rd_data_o), 16'(e));
  endtask

  task automatic prog(input logic [2:0] a, input logic [7:0] d,
                      input logic refuse);
    cmd(otp_store_pkg::OP_PROGRAM, a, d);
    @(negedge mclk_i);
    check(16'(refused_o), 16'(refuse));
  endtask

  task automatic settle;
    repeat (4) @(negedge mclk_i);
  endtask

  task automatic coil(input logic [3:0] c, input logic [9:0] ma);
    settle();
    check(16'(coil_current_code_o), 16'(c));
    check(16'(coil_current_ma_o), 16'(ma));
  endtask

  task automatic node(input logic [6:0] e);
    settle();
    check(16'(node_location_id_o), 16'(e));
  endtask

  // ****************************************************************
  // sequence
  // ****************************************************************
  initial begin
    repeat (2) @(posedge mclk_i);
    rst_n_i <= 1'b1;
    settle();
    check(16'(clock_source_trim_o), 16'h0005);
    check(16'(reference_current_trim_o), 16'h000a);
    check(16'(overtemp_limit_trim_o), 16'h0001);
    check(16'(bandgap_trim_o), 16'h0003);
    node(7'h05);
    coil(4'h0, 10'h03b);
    for (int i = 0; i < 8; i++) begin
      rd(i[2:0], img[i]);
    end
    cmd(otp_store_pkg::OP_LOAD_PARAM, 3'h0, 8'hff);
    settle();
    check(16'(clock_source_trim_o), 16'h0005);
    check(16'(reference_current_trim_o), 16'h000a);
    cmd(otp_store_pkg::OP_LOAD_PARAM, 3'h3, 8'ha5);
    coil(4'ha, 10'h150);
    cmd(otp_store_pkg::OP_RELOAD, 3'h0, 8'h00);
    coil(4'h0, 10'h03b);
    prog(3'h3, 8'ha5, 1'b0);
    coil(4'h0, 10'h03b);
    rd(3'h3, 8'ha5);
    coil(4'ha, 10'h150);
    @(posedge mclk_i);
    motor_stopped_i <= 1'b1;
    coil(4'h5, 10'h08d);
    prog(3'h3, 8'hff, 1'b0);
    rd(3'h3, 8'hff);
    coil(4'hf, 10'h320);
    prog(3'h0, 8'hff, 1'b1);
    prog(3'h1, 8'h0f, 1'b1);
    rd(3'h0, 8'h5a);
    rd(3'h1, 8'h93);
    prog(3'h2, 8'h7c, 1'b0);
    rd(3'h2, 8'h5c);
    node(7'h65);
    cmd(otp_store_pkg::OP_LOAD_PARAM, 3'h2, 8'h8f);
    node(7'h5c);
    rd(3'h2, 8'h5c);
    node(7'h65);
    @(posedge mclk_i);
    strap_pin_bits_i <= 3'h2;
    settle();
    rd(3'h2, 8'h2c);
    node(7'h62);
    for (int k = 0; k < 4; k++) begin
      cmd(otp_store_pkg::OP_LOAD_PARAM, 3'h7, {4'h0, k[1:0], 2'h0});
      settle();
      check(16'(microstep_resolution_o), 16'(k));
      check(16'(microstep_div_o), 16'(2 << k));
    end
    cmd(otp_store_pkg::OP_LOAD_PARAM, 3'h5, 8'hb7);
    cmd(otp_store_pkg::OP_LOAD_PARAM, 3'h6, 8'h3c);
    cmd(otp_store_pkg::OP_LOAD_PARAM, 3'h4, 8'h9e);
    settle();
    check(16'(shaft_dir_o), 16'h0001);
    check(16'(accel_o), 16'h0007);
    check(16'(safe_park_target_o), 16'h053c);
    check(16'(speed_max_o), 16'h0009);
    check(16'(speed_min_o), 16'h000e);
    cmd(otp_store_pkg::OP_RELOAD, 3'h0, 8'h00);
    settle();
    check(16'(shaft_dir_o), 16'h0000);
    check(16'(speed_max_o), 16'h0000);
    prog(3'h7, 8'h01, 1'b0);
    rd(3'h7, 8'h03);
    prog(3'h4, 8'h11, 1'b1);
    prog(3'h7, 8'h04, 1'b1);
    rd(3'h4, 8'h00);
    test_done();
  end
endmodule // test_otp_param_store
`default_nettype wire
